// ---- design/smic_map.vh ----
`ifndef SMIC_MAP_VH
`define SMIC_MAP_VH

// register map
`define SMIC_CTRL_ADDR 8'h32
`define SMIC_CTRL_RST 16'h0000
`define SMIC_MODE_LSB 1
`define SMIC_MODE_MSB 3
`define SMIC_INACT_LSB 4
`define SMIC_INACT_MSB 6

// power mode field values
`define SMIC_MODE_ACT 3'h0
`define SMIC_MODE_ACT_INT 3'h1
`define SMIC_MODE_ACT_SMP 3'h2
`define SMIC_MODE_SLEEP 3'h3
`define SMIC_MODE_SLEEP_SMP 3'h4
`define SMIC_MODE_LP_INT 3'h5
`define SMIC_MODE_LP 3'h6
`define SMIC_MODE_ACT2 3'h7

// interrupt select codes
`define SMIC_SEL_X 4'h0
`define SMIC_SEL_Y 4'h1
`define SMIC_SEL_Z 4'h2
`define SMIC_SEL_AX 4'h3
`define SMIC_SEL_AY 4'h4
`define SMIC_SEL_AZ 4'h5
`define SMIC_SEL_TEMP 4'h6
`define SMIC_SEL_ANGLE 4'h7
`define SMIC_SEL_RADIUS 4'h8
`define SMIC_SEL_NEWDATA 4'h9

// inactive times in microseconds, select 0..7
`define SMIC_INACT0_US 680
`define SMIC_INACT1_US 1360
`define SMIC_INACT2_US 6820
`define SMIC_INACT3_US 13640
`define SMIC_INACT4_US 68180
`define SMIC_INACT5_US 136360
`define SMIC_INACT6_US 681820
`define SMIC_INACT7_US 1363640

// timing
`define SMIC_CLK_PERIOD_NS 8
`define SMIC_CYC_PER_US 125
`define SMIC_CLR_US 20
`define SMIC_CLR_CYC (`SMIC_CLR_US * 1000 / `SMIC_CLK_PERIOD_NS)
`define SMIC_PULSE_US 10
`define SMIC_PULSE_CYC (`SMIC_PULSE_US * 1000 / `SMIC_CLK_PERIOD_NS)
`define SMIC_POD_CYC 125000

`endif

// ---- design/smic_mode_ctrl.v ----
`timescale 1ns/1ps
`include "smic_map.vh"
// Function
// - pin edge or start bit triggers acquisition
// - post results, then raise data ready
// - after triggered acquisition return to standby
// - ignore triggers while acquisition runs
// - one data update per accepted trigger
// - latched ready blocks acquisition until cleared
// - interrupt modes drive pin as output
// - compare selected quantity with volatile limit
// - condition sets flag and pin
// - flag sticky, cleared by writing one
// - pin latch holds pin until flag cleared
// - duty-cycle flag clear completes after 20 us
// - codes 0-2 signed limit above axis
// - codes 3-5 unsigned limit above magnitude
// - codes 6-8 temperature, angle, radius
// - code 9 gives 10 us data pulse
// - mode from control bits 3:1
// - active modes except sample mode 2 refresh continuously, pin per mode
// - sleep stops updates, pin unused
// - sample wake sleep converts per trigger
// - leaving sleep takes power-on delay
// - duty cycle alternates active and inactive
// - control bits 6:4 pick inactive time
// - active phase set by front end
module smic_mode_ctrl #(
    parameter PodCycles = `SMIC_POD_CYC,
    parameter CycPerUs = `SMIC_CYC_PER_US
) (
    input wire clk,
    input wire rst_n,
    input wire regWrEn,
    input wire [7:0] regAddr,
    input wire [15:0] regWrData,
    output wire [15:0] regRdData,
    input wire startSample,
    input wire readyClear,
    input wire irqClear,
    input wire dataLatch,
    input wire pinLatch,
    input wire samplePolarity,
    input wire [3:0] irqSelect,
    input wire irqSign,
    input wire [15:0] irqLimitNonvolatile,
    input wire limitWrEn,
    input wire [15:0] limitWrData,
    output wire [15:0] irqLimitVolatile,
    input wire intPinIn,
    output wire intPinOut,
    output wire intPinOe_n,
    output wire acqStart,
    input wire acqDone,
    input wire [15:0] acqX,
    input wire [15:0] acqY,
    input wire [15:0] acqZ,
    input wire [11:0] acqTemp,
    input wire [14:0] acqAngle,
    input wire [15:0] acqRadius,
    output wire [15:0] dataX,
    output wire [15:0] dataY,
    output wire [15:0] dataZ,
    output wire [11:0] dataTemp,
    output wire [14:0] dataAngle,
    output wire [15:0] dataRadius,
    output wire statusReady,
    output wire irqFlag,
    output wire busy
);

localparam ST_IDLE = 3'h0;
localparam ST_ACQ = 3'h1;
localparam ST_POST = 3'h2;
localparam ST_INACT = 3'h3;
localparam ST_SLEEP = 3'h4;
localparam ST_WAKE = 3'h5;
localparam [11:0] ClrCyc = `SMIC_CLR_CYC;
localparam [10:0] PulseCyc = `SMIC_PULSE_CYC;
// inactive time select to cycles
function [27:0] inactCycles;
    input [2:0] sel;
    reg [31:0] us;
    begin
        case (sel)
            3'h0: us = `SMIC_INACT0_US;
            3'h1: us = `SMIC_INACT1_US;
            3'h2: us = `SMIC_INACT2_US;
            3'h3: us = `SMIC_INACT3_US;
            3'h4: us = `SMIC_INACT4_US;
            3'h5: us = `SMIC_INACT5_US;
            3'h6: us = `SMIC_INACT6_US;
            default: us = `SMIC_INACT7_US;
        endcase
        inactCycles = us[27:0] * CycPerUs[27:0];
    end
endfunction

// reset release
reg rstMeta_ff;
reg rstN_ff;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rstMeta_ff <= 1'b0;
        rstN_ff <= 1'b0;
    end else begin
        rstMeta_ff <= 1'b1;
        rstN_ff <= rstMeta_ff;
    end
end

// control word
reg [15:0] ctrl_ff;
reg [15:0] rdData_ff;
wire [2:0] mode = ctrl_ff[`SMIC_MODE_MSB:`SMIC_MODE_LSB];
wire [2:0] inactSel = ctrl_ff[`SMIC_INACT_MSB:`SMIC_INACT_LSB];
wire ctrlHit = regAddr == `SMIC_CTRL_ADDR;

always @(posedge clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
        ctrl_ff <= `SMIC_CTRL_RST;
        rdData_ff <= 16'h0000;
    end else begin
        if (regWrEn && ctrlHit) begin
            ctrl_ff <= regWrData;
        end
        rdData_ff <= ctrlHit ? ctrl_ff : 16'h0000;
    end
end

// mode decoding
wire sleepMode = (mode == `SMIC_MODE_SLEEP) ||
    (mode == `SMIC_MODE_SLEEP_SMP);
wire sampleMode = (mode == `SMIC_MODE_ACT_SMP) ||
    (mode == `SMIC_MODE_SLEEP_SMP);
wire lpMode = (mode == `SMIC_MODE_LP_INT) ||
    (mode == `SMIC_MODE_LP);
wire intMode = (mode == `SMIC_MODE_ACT_INT) ||
    (mode == `SMIC_MODE_LP_INT);

// sample pin edge
wire pinLevel;
reg pinPrev_ff;
smic_pin_sync uSync (
    .clk(clk),
    .rstN(rstN_ff),
    .pinIn(intPinIn),
    .level(pinLevel)
);
wire pinActive = pinLevel == samplePolarity;
wire pinEdge = (pinLevel != pinPrev_ff) && pinActive;
wire trig = sampleMode && (pinEdge || startSample);
reg statusReady_ff;
wire hold = dataLatch && statusReady_ff;

// sequencer
reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [27:0] cnt_ff;
reg [27:0] nxt_cnt;
reg wakeAcq_ff;
reg nxt_wakeAcq;
reg acqStart_ff;
reg nxt_acqStart;
reg dataValid_ff;

always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_wakeAcq = wakeAcq_ff;
    nxt_acqStart = 1'b0;
    case (state_ff)
        ST_IDLE: begin
            if (sleepMode) begin
                nxt_state = ST_SLEEP;
            end else if (hold) begin
                nxt_state = ST_IDLE;
            end else if (!sampleMode || trig) begin
                nxt_state = ST_ACQ;
                nxt_acqStart = 1'b1;
            end
        end
        ST_ACQ: begin
            if (acqDone) begin
                nxt_state = ST_POST;
            end
        end
        ST_POST: begin
            if (lpMode) begin
                nxt_state = ST_INACT;
                nxt_cnt = inactCycles(inactSel);
            end else begin
                nxt_state = ST_IDLE;
            end
        end
        ST_INACT: begin
            if (!lpMode || cnt_ff <= 28'h0000001) begin
                nxt_state = ST_IDLE;
            end else begin
                nxt_cnt = cnt_ff - 28'h0000001;
            end
        end
        ST_SLEEP: begin
            if (!sleepMode) begin
                nxt_state = ST_WAKE;
                nxt_cnt = PodCycles[27:0];
                nxt_wakeAcq = 1'b0;
            end else if (trig && !hold) begin
                nxt_state = ST_WAKE;
                nxt_cnt = PodCycles[27:0];
                nxt_wakeAcq = 1'b1;
            end
        end
        ST_WAKE: begin
            if (cnt_ff <= 28'h0000001) begin
                if (wakeAcq_ff) begin
                    nxt_state = ST_ACQ;
                    nxt_acqStart = 1'b1;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end else begin
                nxt_cnt = cnt_ff - 28'h0000001;
            end
        end
        default: nxt_state = ST_IDLE;
    endcase
end

// results and ready flag
reg [15:0] dataX_ff;
reg [15:0] dataY_ff;
reg [15:0] dataZ_ff;
reg [11:0] dataTemp_ff;
reg [14:0] dataAngle_ff;
reg [15:0] dataRadius_ff;
wire posting = state_ff == ST_POST;

always @(posedge clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
        state_ff <= ST_IDLE;
        cnt_ff <= 28'h0000000;
        wakeAcq_ff <= 1'b0;
        acqStart_ff <= 1'b0;
        pinPrev_ff <= 1'b0;
        statusReady_ff <= 1'b0;
        dataValid_ff <= 1'b0;
        dataX_ff <= 16'h0000;
        dataY_ff <= 16'h0000;
        dataZ_ff <= 16'h0000;
        dataTemp_ff <= 12'h000;
        dataAngle_ff <= 15'h0000;
        dataRadius_ff <= 16'h0000;
    end else begin
        state_ff <= nxt_state;
        cnt_ff <= nxt_cnt;
        wakeAcq_ff <= nxt_wakeAcq;
        acqStart_ff <= nxt_acqStart;
        pinPrev_ff <= pinLevel;
        if (state_ff == ST_ACQ && acqDone) begin
            dataX_ff <= acqX;
            dataY_ff <= acqY;
            dataZ_ff <= acqZ;
            dataTemp_ff <= acqTemp;
            dataAngle_ff <= acqAngle;
            dataRadius_ff <= acqRadius;
        end
        if (posting) begin
            statusReady_ff <= 1'b1;
            dataValid_ff <= 1'b1;
        end else if (readyClear) begin
            statusReady_ff <= 1'b0;
        end
    end
end

// threshold condition
reg [15:0] limit_ff;
reg limitLoaded_ff;
wire cond;
smic_thr_cmp uCmp (
    .sel(irqSelect),
    .invert(irqSign),
    .limit(limit_ff),
    .valX(dataX_ff),
    .valY(dataY_ff),
    .valZ(dataZ_ff),
    .valTemp(dataTemp_ff),
    .valAngle(dataAngle_ff),
    .valRadius(dataRadius_ff),
    .cond(cond)
);

// interrupt flag and pin
reg irqFlag_ff;
reg clrPend_ff;
reg [11:0] clrCnt_ff;
reg [10:0] pulseCnt_ff;
reg pinOut_ff;
reg pinOe_n_ff;
wire irqCond = intMode && dataValid_ff && cond;
wire newDataSel = irqSelect == `SMIC_SEL_NEWDATA;
wire clrDone = clrPend_ff && clrCnt_ff <= 12'h001;
reg pinLvl;

always @* begin
    if (newDataSel) begin
        pinLvl = pulseCnt_ff != 11'h000;
    end else if (pinLatch) begin
        pinLvl = irqFlag_ff;
    end else begin
        pinLvl = irqCond;
    end
end

always @(posedge clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
        limit_ff <= 16'h0000;
        limitLoaded_ff <= 1'b0;
        irqFlag_ff <= 1'b0;
        clrPend_ff <= 1'b0;
        clrCnt_ff <= 12'h000;
        pulseCnt_ff <= 11'h000;
        pinOut_ff <= 1'b0;
        pinOe_n_ff <= 1'b1;
    end else begin
        limitLoaded_ff <= 1'b1;
        if (!limitLoaded_ff) begin
            limit_ff <= irqLimitNonvolatile;
        end else if (limitWrEn) begin
            limit_ff <= limitWrData;
        end
        if (irqClear && lpMode) begin
            clrPend_ff <= 1'b1;
            clrCnt_ff <= ClrCyc;
        end else if (clrPend_ff) begin
            clrPend_ff <= !clrDone;
            clrCnt_ff <= clrCnt_ff - 12'h001;
        end
        if (irqCond) begin
            irqFlag_ff <= 1'b1;
        end else if ((irqClear && !lpMode) || clrDone) begin
            irqFlag_ff <= 1'b0;
        end
        if (posting && intMode && newDataSel) begin
            pulseCnt_ff <= PulseCyc;
        end else if (pulseCnt_ff != 11'h000) begin
            pulseCnt_ff <= pulseCnt_ff - 11'h001;
        end
        pinOut_ff <= samplePolarity ? pinLvl : !pinLvl;
        pinOe_n_ff <= !intMode;
    end
end

assign regRdData = rdData_ff;
assign irqLimitVolatile = limit_ff;
assign intPinOut = pinOut_ff;
assign intPinOe_n = pinOe_n_ff;
assign acqStart = acqStart_ff;
assign dataX = dataX_ff;
assign dataY = dataY_ff;
assign dataZ = dataZ_ff;
assign dataTemp = dataTemp_ff;
assign dataAngle = dataAngle_ff;
assign dataRadius = dataRadius_ff;
assign statusReady = statusReady_ff;
assign irqFlag = irqFlag_ff;
assign busy = state_ff == ST_ACQ || state_ff == ST_POST;

endmodule // smic_mode_ctrl

// ---- design/smic_pin_sync.v ----
`timescale 1ns/1ps
// three-stage pin synchroniser, level taken when stages two and three agree
module smic_pin_sync (
    clk,
    rstN,
    pinIn,
    level
);
input wire clk;
input wire rstN;
input wire pinIn;
output wire level;

reg s1_ff;
reg s2_ff;
reg s3_ff;
reg level_ff;

always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        s3_ff <= 1'b0;
        level_ff <= 1'b0;
    end else begin
        s1_ff <= pinIn;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff) begin
            level_ff <= s3_ff;
        end
    end
end

assign level = level_ff;

endmodule // smic_pin_sync

// ---- design/smic_thr_cmp.v ----
`timescale 1ns/1ps
`include "smic_map.vh"
// threshold comparison on the selected output quantity
module smic_thr_cmp (
    sel,
    invert,
    limit,
    valX,
    valY,
    valZ,
    valTemp,
    valAngle,
    valRadius,
    cond
);
input wire [3:0] sel;
input wire invert;
input wire [15:0] limit;
input wire [15:0] valX;
input wire [15:0] valY;
input wire [15:0] valZ;
input wire [11:0] valTemp;
input wire [14:0] valAngle;
input wire [15:0] valRadius;
output reg cond;

function [16:0] absVal;
    input [15:0] v;
    begin
        absVal = v[15] ? (17'h00000 - {v[15], v}) : {1'b0, v};
    end
endfunction

reg signed [16:0] thr;
reg signed [16:0] val;
reg usable;

always @* begin
    thr = {limit[15], limit};
    val = 17'h00000;
    usable = 1'b1;
    case (sel)
        `SMIC_SEL_X: val = {valX[15], valX};
        `SMIC_SEL_Y: val = {valY[15], valY};
        `SMIC_SEL_Z: val = {valZ[15], valZ};
        `SMIC_SEL_AX: begin
            thr = {1'b0, limit};
            val = absVal(valX);
        end
        `SMIC_SEL_AY: begin
            thr = {1'b0, limit};
            val = absVal(valY);
        end
        `SMIC_SEL_AZ: begin
            thr = {1'b0, limit};
            val = absVal(valZ);
        end
        `SMIC_SEL_TEMP: val = {{5{valTemp[11]}}, valTemp};
        `SMIC_SEL_ANGLE: begin
            thr = {1'b0, limit};
            val = {2'h0, valAngle};
        end
        `SMIC_SEL_RADIUS: begin
            thr = {1'b0, limit};
            val = {1'b0, valRadius};
        end
        default: usable = 1'b0;
    endcase
    if (!usable) begin
        cond = 1'b0;
    end else if (invert) begin
        cond = val > thr;
    end else begin
        cond = thr > val;
    end
end

endmodule // smic_thr_cmp

// ---- tb/smic_asserts.sv ----
`timescale 1ns/1ps
module smic_asserts #(parameter PodCycles = 20, parameter CycPerUs = 1) (
    input wire clk,
    input wire rst_n,
    input wire regWrEn,
    input wire [7:0] regAddr,
    input wire [15:0] regWrData,
    input wire irqClear,
    input wire dataLatch,
    input wire acqStart,
    input wire acqDone,
    input wire [15:0] acqX,
    input wire [15:0] dataX,
    input wire busy,
    input wire statusReady,
    input wire irqFlag,
    input wire intPinOe_n
);
reg [2:0] mode_ff;
wire ctrlWr = regWrEn && regAddr == 8'h32;
wire lpMode = mode_ff == 3'h5 || mode_ff == 3'h6;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
        mode_ff <= 3'h0;
    else if (ctrlWr)
        mode_ff <= regWrData[3:1];
end
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
start_busy_a: assert property (acqStart |-> busy ##1 busy)
    else $error("start outside busy");
post_data_a: assert property (acqDone && busy |=> dataX == $past(acqX))
    else $error("data not posted");
ready_set_a: assert property (acqDone && busy |-> ##2 statusReady)
    else $error("ready not set");
data_hold_a: assert property (!(acqDone && busy) |=> $stable(dataX))
    else $error("data changed");
latch_hold_a: assert property (dataLatch && statusReady &&
    $past(statusReady) |-> !acqStart) else $error("start while held");
irq_sticky_a: assert property (irqFlag && !irqClear && !lpMode |=> irqFlag)
    else $error("flag dropped");
lp_clear_a: assert property (irqClear && irqFlag && lpMode |=> irqFlag [*8])
    else $error("flag cleared early");
oe_drive_a: assert property (ctrlWr && regWrData[3:1] == 3'h1
    |-> ##[1:4] !intPinOe_n) else $error("pin not driven");
oe_sleep_a: assert property (ctrlWr && regWrData[3:1] == 3'h3
    |-> ##[1:4] intPinOe_n) else $error("pin driven in sleep");
cover property (acqDone && busy && dataLatch);
cover property (irqFlag && !intPinOe_n);
cover property (irqClear && irqFlag && lpMode);
endmodule // smic_asserts
bind smic_mode_ctrl smic_asserts #(.PodCycles(PodCycles), .CycPerUs(CycPerUs))
    chk (.clk, .rst_n, .regWrEn, .regAddr, .regWrData, .irqClear, .dataLatch,
    .acqStart, .acqDone, .acqX, .dataX, .busy, .statusReady, .irqFlag,
    .intPinOe_n);

// ---- tb/smic_fe_model.sv ----
`timescale 1ns/1ps
// front end stand-in: answers each start lat+1 cycles after it is sampled
module smic_fe_model (
    input wire clk,
    input wire acqStart,
    input wire [9:0] lat,
    input wire [15:0] seed,
    output reg acqDone = 1'b0,
    output wire [15:0] acqX,
    output wire [15:0] acqY,
    output wire [15:0] acqZ,
    output wire [11:0] acqTemp,
    output wire [14:0] acqAngle,
    output wire [15:0] acqRadius
);
reg [9:0] cnt = 10'h000;
reg run = 1'b0;
// results are only valid in the done cycle, inverted otherwise
wire [15:0] v = acqDone ? seed : ~seed;
assign acqX = v;
assign acqY = v ^ 16'h8001;
assign acqZ = {v[7:0], v[15:8]};
assign acqTemp = v[11:0];
assign acqAngle = v[14:0];
assign acqRadius = v ^ 16'h0f0f;
always @(posedge clk) begin
    acqDone <= 1'b0;
    if (acqStart) begin
        run <= 1'b1;
        cnt <= lat;
    end else if (run && cnt == 10'h000) begin
        run <= 1'b0;
        acqDone <= 1'b1;
    end else if (run) begin
        cnt <= cnt - 10'h001;
    end
end
endmodule // smic_fe_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
reg clk = 1'b0;
reg rst_n = 1'b0;
reg regWrEn = 1'b0;
reg [7:0] regAddr = 8'h00;
reg [15:0] regWrData = 16'h0000;
reg [3:0] pul = 4'h0;
reg dataLatch = 1'b0;
reg pinLatch = 1'b0;
reg samplePolarity = 1'b1;
reg [3:0] irqSelect = 4'h0;
reg irqSign = 1'b0;
reg [15:0] limWr = 16'h0000;
reg hostPin = 1'b1;
reg [9:0] lat = 10'h004;
reg [15:0] seed = 16'h0000;
reg [31:0] rs = 32'h000115e9;
integer fails = 0;
integer cmp_count = 0;
integer nStart = 0;
integer i;
integer k;
reg [15:0] r;
reg [15:0] lim;
wire [15:0] regRdData, irqLimitVolatile, acqX, acqY, acqZ, acqRadius;
wire [15:0] dataX, dataY, dataZ, dataRadius;
wire [11:0] acqTemp, dataTemp;
wire [14:0] acqAngle, dataAngle;
wire intPinOut, intPinOe_n, acqStart, acqDone, statusReady, irqFlag, busy;
wire pinWire = !intPinOe_n ? intPinOut : hostPin;
smic_mode_ctrl #(.PodCycles(20), .CycPerUs(1)) uut (.clk, .rst_n, .regWrEn,
    .regAddr, .regWrData, .regRdData, .startSample(pul[0]),
    .readyClear(pul[1]), .irqClear(pul[2]), .dataLatch, .pinLatch,
    .samplePolarity, .irqSelect, .irqSign, .irqLimitNonvolatile(16'h1234),
    .limitWrEn(pul[3]), .limitWrData(limWr), .irqLimitVolatile,
    .intPinIn(pinWire), .intPinOut, .intPinOe_n, .acqStart, .acqDone, .acqX,
    .acqY, .acqZ, .acqTemp, .acqAngle, .acqRadius, .dataX, .dataY, .dataZ,
    .dataTemp, .dataAngle, .dataRadius, .statusReady, .irqFlag, .busy);
smic_fe_model fe (.clk, .acqStart, .lat, .seed, .acqDone, .acqX, .acqY,
    .acqZ, .acqTemp, .acqAngle, .acqRadius);
initial begin
    forever #4 clk = ~clk;
end
always @(posedge clk) if (acqStart) nStart <= nStart + 1;
function automatic logic [15:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    rnd = rs[15:0];
endfunction
function automatic logic signed [16:0] ab(input [15:0] x);
    ab = x[15] ? -$signed({1'b1, x}) : $signed({1'b0, x});
endfunction
function automatic logic cnd(input [3:0] s, input g, input [15:0] t, v);
    logic signed [16:0] q;
    logic signed [16:0] l;
    logic [15:0] y;
    logic [15:0] z;
    y = v ^ 16'h8001;
    z = {v[7:0], v[15:8]};
    l = (s < 4'h3 || s == 4'h6) ? {t[15], t} : {1'b0, t};
    case (s)
        4'h0: q = {v[15], v};
        4'h1: q = {y[15], y};
        4'h2: q = {z[15], z};
        4'h3: q = ab(v);
        4'h4: q = ab(y);
        4'h5: q = ab(z);
        4'h6: q = {{5{v[11]}}, v[11:0]};
        4'h7: q = {2'b00, v[14:0]};
        default: q = {1'b0, v ^ 16'h0f0f};
    endcase
    cnd = g ? q > l : l > q;
endfunction
task chk(input [15:0] s, input [15:0] e, input [79:0] n);
    cmp_count++;
    if (s !== e) begin
        fails++;
        $display("mismatch %0s exp %h seen %h", n, e, s);
    end
endtask
task done(input [47:0] n);
    $display("test %0s done", n);
endtask
task stop_test;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task wr(input [7:0] a, input [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    @(posedge clk);
endtask
task rd(input [7:0] a, input [15:0] e);
    regAddr <= a;
    repeat (2) @(posedge clk);
    chk(regRdData, e, "rd");
endtask
task pulse(input [3:0] m);
    pul <= m;
    @(posedge clk);
    pul <= 4'h0;
    @(posedge clk);
endtask
task cyc(input integer n);
    repeat (n) @(posedge clk);
endtask
initial begin
    cyc(20000);
    fails++;
    stop_test;
end
initial begin
    cyc(10);
    rst_n <= 1'b1;
    cyc(4);
    rd(8'h32, 16'h0000);
    chk(irqLimitVolatile, 16'h1234, "nvlimit");
    r = rnd();
    wr(8'h32, r);
    rd(8'h32, r);
    wr(8'h55, ~r);
    rd(8'h32, r);
    rd(8'h55, 16'h0000);
    done("regs");
    wr(8'h32, 16'h0004);
    cyc(60);
    seed <= rnd();
    k = nStart;
    pulse(4'h1);
    pulse(4'h1);
    cyc(30);
    chk(16'(nStart - k), 16'h0001, "starts");
    chk(dataX, seed, "x");
    chk(dataY, seed ^ 16'h8001, "y");
    chk(dataZ, {seed[7:0], seed[15:8]}, "z");
    chk({4'h0, dataTemp}, {4'h0, seed[11:0]}, "temp");
    chk({1'b0, dataAngle}, {1'b0, seed[14:0]}, "angle");
    chk(dataRadius, seed ^ 16'h0f0f, "radius");
    chk(statusReady, 16'h0001, "ready");
    samplePolarity <= 1'b0;
    cyc(8);
    hostPin <= 1'b0;
    cyc(30);
    chk(16'(nStart - k), 16'h0002, "pinstart");
    samplePolarity <= 1'b1;
    dataLatch <= 1'b1;
    pulse(4'h1);
    cyc(20);
    chk(16'(nStart - k), 16'h0002, "held");
    pulse(4'h2);
    pulse(4'h1);
    cyc(30);
    chk(16'(nStart - k), 16'h0003, "released");
    dataLatch <= 1'b0;
    done("sample");
    wr(8'h32, 16'h0002);
    for (i = 0; i < 9; i++) begin
        r = rnd();
        lim = (i == 0) ? r : rnd();
        seed <= r;
        irqSelect <= i[3:0];
        irqSign <= lim[0];
        limWr <= lim;
        pulse(4'h8);
        cyc(40);
        pulse(4'h4);
        cyc(3);
        chk(irqFlag, cnd(i[3:0], lim[0], lim, r), "flag");
        chk(intPinOut, cnd(i[3:0], lim[0], lim, r), "pin");
        chk(irqLimitVolatile, lim, "limit");
    end
    pinLatch <= 1'b1;
    irqSign <= 1'b0;
    irqSelect <= 4'h3;
    limWr <= 16'hffff;
    pulse(4'h8);
    cyc(20);
    limWr <= 16'h0000;
    pulse(4'h8);
    cyc(20);
    chk(intPinOut, 16'h0001, "latched");
    pulse(4'h4);
    cyc(3);
    chk({irqFlag, intPinOut}, 16'h0000, "cleared");
    pinLatch <= 1'b0;
    done("irq");
    lat <= 10'h2bc;
    wr(8'h32, 16'h000a);
    irqSelect <= 4'h9;
    k = 0;
    while (intPinOut !== 1'b1 && k < 3000) begin
        @(posedge clk);
        k++;
    end
    k = 0;
    while (intPinOut === 1'b1 && k < 3000) begin
        @(posedge clk);
        k++;
    end
    chk(16'(k), 16'h04e2, "pulse");
    irqSelect <= 4'h3;
    limWr <= 16'hffff;
    pulse(4'h8);
    cyc(20);
    limWr <= 16'h0000;
    pulse(4'h8);
    pulse(4'h4);
    cyc(2400);
    chk(irqFlag, 16'h0001, "lpflag");
    cyc(200);
    chk(irqFlag, 16'h0000, "lpflag");
    done("lowpwr");
    lat <= 10'h004;
    wr(8'h32, 16'h0006);
    cyc(1500);
    k = nStart;
    pulse(4'h1);
    cyc(100);
    chk(16'(nStart - k), 16'h0000, "sleep");
    wr(8'h32, 16'h0008);
    cyc(40);
    k = nStart;
    i = 0;
    hostPin <= 1'b1;
    while (nStart == k && i < 200) begin
        @(posedge clk);
        i++;
    end
    chk(16'(i >= 20 && i < 40), 16'h0001, "wake");
    cyc(100);
    chk(16'(nStart - k), 16'h0001, "standby");
    done("sleep");
    stop_test;
end
endmodule // testbench
